// ===== rtl/adcc_regs.vh
// register map, field positions, reset values and timing counts of the converter control
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// register byte addresses
`define ADCC_CTRL0_ADDR      8'h00
`define ADCC_CTRL1_ADDR      8'h04
`define ADCC_RESULT_ADDR     8'h08
`define ADCC_STATUS_ADDR     8'h0c
`define ADCC_MASK_ADDR       8'h10

// converter_control_0 fields
`define ADCC_ON_BIT          0
`define ADCC_ACTIVE_BIT      1
`define ADCC_SEL_LSB         2
`define ADCC_SEL_MSB         5
`define ADCC_CTRL0_RESET     8'h00

// converter_control_1 fields
`define ADCC_REFSEL_LSB      0
`define ADCC_REFSEL_MSB      1
`define ADCC_CLKSEL_LSB      4
`define ADCC_CLKSEL_MSB      6
`define ADCC_CTRL1_RESET     8'h00
`define ADCC_CTRL1_MASK      8'h73

// input_select codes
`define ADCC_SEL_LAST_PIN    4'hd
`define ADCC_SEL_RESERVED    4'he
`define ADCC_SEL_FIXED_REF   4'hf

// status and mask fields
`define ADCC_DONE_BIT        0
`define ADCC_RESULT_RESET    8'h00
`define ADCC_MASK_RESET      1'b0

// bus answers
`define ADCC_RESP_OKAY       2'b00
`define ADCC_RESP_SLVERR     2'b10

// timing: acquisition time in ns and clock in MHz, cycles rounded up
`define ADCC_CLK_MHZ         200
`define ADCC_ACQ_NS          2000
`define ADCC_ACQ_CYC         ((`ADCC_ACQ_NS * `ADCC_CLK_MHZ + 999) / 1000)
// shortest bit time in cycles, doubled per step of conversion_clock_select
`define ADCC_BIT_CYC_MIN     9'd2

`endif

// ===== rtl/adcc_sar.v
// successive-approximation sequencer: acquisition, eight bit decisions, abort with fill
`default_nettype none

`include "adcc_regs.vh"

module adcc_sar (
	// clock and reset
	input  wire       clk,
	input  wire       rst_b,
	// control from the register file
	input  wire       start,
	input  wire       abort,
	input  wire [2:0] clk_sel,
	// comparator, already synchronised
	input  wire       comp,
	// state and results
	output wire       busy,
	output reg        done,
	output reg  [7:0] result,
	output reg  [7:0] dac,
	output reg        sample
);

	localparam ST_IDLE = 2'b00;
	localparam ST_ACQ  = 2'b01;
	localparam ST_CONV = 2'b10;

	// acquisition load; the top bits of the count are never needed
	localparam integer ACQ_LOAD = `ADCC_ACQ_CYC - 1;

	reg [1:0] state;
	reg [8:0] cnt;
	reg [2:0] bit_idx;
	reg [7:0] code;
	reg       last_bit;

	// bits above idx kept, idx and below copy the last decided bit
	function [7:0] fill_code;
		input [7:0] c;
		input [2:0] idx;
		input       lb;
		integer     i;
		begin
			fill_code = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (i <= idx)
					fill_code[i] = lb;
			end
		end
	endfunction

	// cycles per bit decision minus one
	function [8:0] bit_time;
		input [2:0] sel;
		begin
			bit_time = (`ADCC_BIT_CYC_MIN << sel) - 9'd1;
		end
	endfunction

	assign busy = (state != ST_IDLE);

	// sequencer; abort wins over a bit decision in the same cycle
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= ST_IDLE;
			cnt      <= 9'h000;
			bit_idx  <= 3'h7;
			code     <= 8'h00;
			last_bit <= 1'b0;
			done     <= 1'b0;
			result   <= `ADCC_RESULT_RESET;
			dac      <= 8'h00;
			sample   <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start) begin
					state    <= ST_ACQ;
					cnt      <= ACQ_LOAD[8:0];
					bit_idx  <= 3'h7;
					code     <= 8'h00;
					last_bit <= 1'b0;
					sample   <= 1'b1;
				end
			end
			ST_ACQ: begin
				if (abort) begin
					result <= fill_code(code, bit_idx, last_bit);
					state  <= ST_IDLE;
					sample <= 1'b0;
				end else if (cnt == 9'h000) begin
					state  <= ST_CONV;
					sample <= 1'b0;
					cnt    <= bit_time(clk_sel);
					dac    <= 8'h80;
				end else begin
					cnt <= cnt - 9'd1;
				end
			end
			ST_CONV: begin
				if (abort) begin
					result <= fill_code(code, bit_idx, last_bit);
					state  <= ST_IDLE;
				end else if (cnt == 9'h000) begin
					code[bit_idx] <= comp;
					last_bit      <= comp;
					if (bit_idx == 3'h0) begin
						result <= {code[7:1], comp};
						done   <= 1'b1;
						state  <= ST_IDLE;
					end else begin
						bit_idx <= bit_idx - 3'd1;
						cnt     <= bit_time(clk_sel);
						dac     <= (code | ({7'h00, comp} << bit_idx))
							| (8'h01 << (bit_idx - 3'd1));
					end
				end else begin
					cnt <= cnt - 9'd1;
				end
			end
			default: begin
				state  <= ST_IDLE;
				sample <= 1'b0;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== rtl/adcc_top.v
// converter control: registers over AXI4-Lite, channel routing, start, trigger and interrupt
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`default_nettype none

`include "adcc_regs.vh"

module adcc_top (
	// clock and reset
	input  wire        MCLK,
	input  wire        RST_B,
	// AXI4-Lite write address
	input  wire        AWVALID,
	output reg         AWREADY,
	input  wire [7:0]  AWADDR,
	input  wire [2:0]  AWPROT,
	// AXI4-Lite write data
	input  wire        WVALID,
	output reg         WREADY,
	input  wire [31:0] WDATA,
	input  wire [3:0]  WSTRB,
	// AXI4-Lite write response
	output reg         BVALID,
	input  wire        BREADY,
	output reg  [1:0]  BRESP,
	// AXI4-Lite read address
	input  wire        ARVALID,
	output reg         ARREADY,
	input  wire [7:0]  ARADDR,
	input  wire [2:0]  ARPROT,
	// AXI4-Lite read data
	output reg         RVALID,
	input  wire        RREADY,
	output reg  [31:0] RDATA,
	output reg  [1:0]  RRESP,
	// compare unit, same clock
	input  wire        SPECIAL_EVENT,
	output reg         TMR1_CLEAR,
	// analog front end
	input  wire        COMP_IN,
	output reg         ADC_POWER,
	output wire        ADC_SAMPLE,
	output wire [7:0]  ADC_DAC,
	output reg  [13:0] ADC_CHAN_EN,
	output reg         ADC_FIXED_REFERENCE_EN,
	output reg  [1:0]  ADC_REF_SEL,
	// interrupt
	output reg         IRQ
);

	// control 0 is kept as fields; the active bit lives in the sequencer
	// software-visible state
	reg        converter_on;
	reg [3:0]  input_select;
	reg [7:0]  converter_control_1;
	reg        conversion_done_flag;
	reg        done_mask;

	// write channel holding
	reg [7:0]  wr_addr;
	reg [31:0] wr_data;
	reg [3:0]  wr_strb;

	// comparator synchroniser
	reg        comp_meta;
	reg        comp_sync;

	// sequencer links
	wire       sar_busy;
	wire       sar_done;
	wire [7:0] conversion_result;
	reg        sar_start;
	reg        sar_abort;

	// bus write and read strobes per register
	wire       wr_fire;
	wire       wr_ctrl0;
	wire       wr_ctrl1;
	wire       wr_mask;
	wire       rd_fire;
	wire       rd_status;
	wire       next_on;
	// next-edge views of select, status and interrupt
	wire [3:0] next_select;
	wire       status_now;
	wire       next_irq;

	// reserved and reference codes light no pin
	// one-hot pin enables for a select code
	function [13:0] pin_decode;
		input [3:0] sel;
		begin
			if (sel <= `ADCC_SEL_LAST_PIN)
				pin_decode = 14'h0001 << sel;
			else
				pin_decode = 14'h0000;
		end
	endfunction

	// anything else answers slverr and changes nothing
	// address is one of the mapped words
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `ADCC_CTRL0_ADDR) || (a == `ADCC_CTRL1_ADDR)
				|| (a == `ADCC_RESULT_ADDR) || (a == `ADCC_STATUS_ADDR)
				|| (a == `ADCC_MASK_ADDR);
		end
	endfunction

	// reset image of control 0, split into its fields below
	localparam [7:0] CTRL0_RST = `ADCC_CTRL0_RESET;

	// a write lands once both halves are held; readies stay low until the response
	// is taken, which costs throughput but keeps a second write from racing the first
	assign wr_fire   = !AWREADY && !WREADY && !BVALID;
	assign wr_ctrl0  = wr_fire && wr_strb[0] && (wr_addr == `ADCC_CTRL0_ADDR);
	assign wr_ctrl1  = wr_fire && wr_strb[0] && (wr_addr == `ADCC_CTRL1_ADDR);
	assign wr_mask   = wr_fire && wr_strb[0] && (wr_addr == `ADCC_MASK_ADDR);
	assign rd_fire   = ARVALID && ARREADY;
	assign rd_status = rd_fire && (ARADDR == `ADCC_STATUS_ADDR);
	assign next_on   = wr_ctrl0 ? wr_data[`ADCC_ON_BIT] : converter_on;
	// routing follows the value being written, so the pin is on when sampling begins
	assign next_select = wr_ctrl0 ? wr_data[`ADCC_SEL_MSB:`ADCC_SEL_LSB] : input_select;
	// a completion in a status-read cycle must still be seen by that read
	assign status_now  = conversion_done_flag || sar_done;
	// the mask only gates the pin; the flag sets while masked as well
	assign next_irq    = status_now && done_mask && !(rd_status && !sar_done);

	// comparator is asynchronous to MCLK
	// only the second stage feeds the sequencer, never the first
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			comp_meta <= 1'b0;
			comp_sync <= 1'b0;
		end else begin
			comp_meta <= COMP_IN;
			comp_sync <= comp_meta;
		end
	end

	// one write and one read may be under way at once, each alone on its channel
	// write address and data are taken in either order, answered once both held
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			AWREADY <= 1'b1;
			WREADY  <= 1'b1;
			BVALID  <= 1'b0;
			BRESP   <= `ADCC_RESP_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				wr_addr <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				wr_data <= WDATA;
				wr_strb <= WSTRB;
				WREADY  <= 1'b0;
			end
			if (wr_fire) begin
				BVALID <= 1'b1;
				BRESP  <= mapped(wr_addr) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
			end
			if (BVALID && BREADY) begin
				BVALID  <= 1'b0;
				AWREADY <= 1'b1;
				WREADY  <= 1'b1;
			end
		end
	end

	// software registers; bits 7 and 6 of control 0 are never stored
	// result and status take no writes: such a write answers okay and changes nothing
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			converter_on        <= CTRL0_RST[`ADCC_ON_BIT];
			input_select        <= CTRL0_RST[`ADCC_SEL_MSB:`ADCC_SEL_LSB];
			converter_control_1 <= `ADCC_CTRL1_RESET;
			done_mask           <= `ADCC_MASK_RESET;
		end else begin
			if (wr_ctrl0) begin
				converter_on <= wr_data[`ADCC_ON_BIT];
				input_select <= wr_data[`ADCC_SEL_MSB:`ADCC_SEL_LSB];
			end
			if (wr_ctrl1)
				converter_control_1 <= wr_data[7:0] & `ADCC_CTRL1_MASK;
			if (wr_mask)
				done_mask <= wr_data[`ADCC_DONE_BIT];
		end
	end

	// start, abort and trigger handling
	// a trigger while busy is dropped here; only the timer clear below sees it
	always @* begin
		sar_start = 1'b0;
		sar_abort = 1'b0;
		if (!sar_busy) begin
			if (wr_ctrl0 && wr_data[`ADCC_ACTIVE_BIT] && next_on)
				sar_start = 1'b1;
			if (SPECIAL_EVENT && next_on)
				sar_start = 1'b1;
		end else begin
			// writing zero to the active bit or switching off stops the sequencer
			// early stop
			if (wr_ctrl0 && !wr_data[`ADCC_ACTIVE_BIT])
				sar_abort = 1'b1;
			if (!next_on)
				sar_abort = 1'b1;
		end
	end

	// the clear is a one-cycle echo of the trigger, busy or not
	// Timer1 clear pulse
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			TMR1_CLEAR <= 1'b0;
		else
			TMR1_CLEAR <= SPECIAL_EVENT;
	end

	// sticky done flag
	// set wins over the clear-on-read in the same cycle
	// hardware only ever sets the flag; software clears it by reading status
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			conversion_done_flag <= 1'b0;
		else if (sar_done)
			conversion_done_flag <= 1'b1;
		else if (rd_status)
			conversion_done_flag <= 1'b0;
	end

	// level interrupt, stored from the flag value of the next edge
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			IRQ <= 1'b0;
		else
			IRQ <= next_irq;
	end

	// routing outputs to the analog side
	// power and pin enables drop with next_on, so an off converter loads no pin
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ADC_POWER    <= 1'b0;
			ADC_CHAN_EN  <= 14'h0000;
			ADC_FIXED_REFERENCE_EN <= 1'b0;
			ADC_REF_SEL  <= 2'h0;
		end else begin
			ADC_POWER    <= next_on;
			ADC_CHAN_EN  <= next_on ? pin_decode(next_select) : 14'h0000;
			// fixed reference, reserved code routes nothing
			ADC_FIXED_REFERENCE_EN <= next_on && (next_select == `ADCC_SEL_FIXED_REF);
			// reference choice is passed through untouched
			ADC_REF_SEL  <= converter_control_1[`ADCC_REFSEL_MSB:`ADCC_REFSEL_LSB];
		end
	end

	// read channel; answer one cycle after the address is taken
	// reads never stall: every word is built from registers in one cycle
	always @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= `ADCC_RESP_OKAY;
		end else begin
			if (rd_fire) begin
				ARREADY <= 1'b0;
				RVALID  <= 1'b1;
				RRESP   <= mapped(ARADDR) ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
				case (ARADDR)
				`ADCC_CTRL0_ADDR: begin
					RDATA <= {26'h0, input_select, sar_busy, converter_on};
				end
				`ADCC_CTRL1_ADDR: begin
					RDATA <= {24'h000000, converter_control_1};
				end
				`ADCC_RESULT_ADDR: begin
					RDATA <= {24'h000000, conversion_result};
				end
				// reading status returns the flag and clears it in the same step
				`ADCC_STATUS_ADDR: begin
					RDATA <= {31'h0, status_now};
				end
				`ADCC_MASK_ADDR: begin
					RDATA <= {31'h0, done_mask};
				end
				default: begin
					RDATA <= 32'h0000_0000;
				end
				endcase
			end
			if (RVALID && RREADY) begin
				RVALID  <= 1'b0;
				ARREADY <= 1'b1;
			end
		end
	end

	// busy drops by itself at completion
	// the sequencer runs on the synchronised comparator, two edges late
	adcc_sar adcc_sar_inst (
		.clk     (MCLK),
		.rst_b   (RST_B),
		.start   (sar_start),
		.abort   (sar_abort),
		.clk_sel (converter_control_1[`ADCC_CLKSEL_MSB:`ADCC_CLKSEL_LSB]),
		.comp    (comp_sync),
		.busy    (sar_busy),
		.done    (sar_done),
		.result  (conversion_result),
		.dac     (ADC_DAC),
		.sample  (ADC_SAMPLE)
	);

endmodule

`default_nettype wire

// ===== sim/adcc_properties.sv
// assertion checker bound to the converter control top
`default_nettype none
`include "adcc_regs.vh"
module adcc_props (
	// clock and reset
	input wire logic        MCLK,
	input wire logic        RST_B,
	// bus handshakes
	input wire logic        AWREADY,
	input wire logic        WREADY,
	input wire logic        BVALID,
	input wire logic        ARREADY,
	input wire logic        RVALID,
	// trigger and front end
	input wire logic        SPECIAL_EVENT,
	input wire logic        TMR1_CLEAR,
	input wire logic        ADC_POWER,
	input wire logic        ADC_SAMPLE,
	input wire logic [7:0]  ADC_DAC,
	input wire logic [13:0] ADC_CHAN_EN,
	input wire logic        ADC_FIXED_REFERENCE_EN
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	// run length of sampling, counted so a stuck sample shows
	logic [9:0] acq_cnt;
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B)
			acq_cnt <= 10'h0;
		else
			acq_cnt <= ADC_SAMPLE ? acq_cnt + 10'h1 : 10'h0;
	end
	property p_tmr;
		SPECIAL_EVENT |=> TMR1_CLEAR;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer clear missing");
	property p_tmr_only;
		!SPECIAL_EVENT |=> !TMR1_CLEAR;
	endproperty
	a_tmr_only: assert property (p_tmr_only) else $error("stray timer clear");
	property p_sel;
		$onehot0(ADC_CHAN_EN) && !(ADC_FIXED_REFERENCE_EN && |ADC_CHAN_EN);
	endproperty
	a_sel: assert property (p_sel) else $error("input routing overlap");
	property p_off;
		!ADC_POWER && !$past(ADC_POWER) |-> ADC_CHAN_EN == 14'h0 && !ADC_FIXED_REFERENCE_EN;
	endproperty
	a_off: assert property (p_off) else $error("routing while off");
	property p_acq;
		ADC_SAMPLE |-> acq_cnt < 10'(`ADCC_ACQ_CYC);
	endproperty
	a_acq: assert property (p_acq) else $error("sampling too long");
	property p_acq_len;
		$fell(ADC_SAMPLE) && ADC_DAC == 8'h80 |-> acq_cnt == 10'(`ADCC_ACQ_CYC);
	endproperty
	a_acq_len: assert property (p_acq_len) else $error("sampling length wrong");
	property p_b_rdy;
		$rose(BVALID) |-> !AWREADY && !WREADY;
	endproperty
	a_b_rdy: assert property (p_b_rdy) else $error("ready during response");
	property p_r_rdy;
		$rose(RVALID) |-> !ARREADY ##1 (!ARREADY || !RVALID);
	endproperty
	a_r_rdy: assert property (p_r_rdy) else $error("read ready during data");
	// main scenarios reached
	cover property (SPECIAL_EVENT ##1 TMR1_CLEAR);
	cover property ($fell(ADC_SAMPLE));
	cover property (ADC_FIXED_REFERENCE_EN);
endmodule
bind adcc_top adcc_props adcc_props_inst (.MCLK, .RST_B, .AWREADY, .WREADY, .BVALID,
	.ARREADY, .RVALID, .SPECIAL_EVENT, .TMR1_CLEAR, .ADC_POWER, .ADC_SAMPLE,
	.ADC_DAC, .ADC_CHAN_EN, .ADC_FIXED_REFERENCE_EN);
`default_nettype wire

// ===== sim/adcc_tb.sv
// self-checking bench for the converter control block
`default_nettype none
`include "adcc_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        MCLK = 1'b0, RST_B = 1'b0, COMP_IN = 1'b0, SPECIAL_EVENT = 1'b0;
	logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic        ARVALID = 1'b0, RREADY = 1'b0;
	logic [7:0]  AWADDR = 8'h0, ARADDR = 8'h0, ADC_DAC;
	logic [31:0] WDATA = 32'h0, RDATA, rdat;
	logic [1:0]  BRESP, RRESP, ADC_REF_SEL, wresp, rresp;
	logic [13:0] ADC_CHAN_EN;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TMR1_CLEAR;
	logic        ADC_POWER, ADC_SAMPLE, ADC_FIXED_REFERENCE_EN, IRQ;
	int          error_cnt = 0, n_tests = 0, cyc = 0, t0;
	adcc_top adcc_top_inst (.MCLK, .RST_B, .AWVALID, .AWREADY, .AWADDR, .AWPROT(3'h0),
		.WVALID, .WREADY, .WDATA, .WSTRB(4'hf), .BVALID, .BREADY, .BRESP, .ARVALID,
		.ARREADY, .ARADDR, .ARPROT(3'h0), .RVALID, .RREADY, .RDATA, .RRESP,
		.SPECIAL_EVENT, .TMR1_CLEAR, .COMP_IN, .ADC_POWER, .ADC_SAMPLE, .ADC_DAC,
		.ADC_CHAN_EN, .ADC_FIXED_REFERENCE_EN, .ADC_REF_SEL, .IRQ);
	always #2.5 MCLK = ~MCLK;
	// hang guard, over ten times the cycles needed
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge MCLK);
		AWVALID <= 1'b1;
		AWADDR <= a;
		WVALID <= 1'b1;
		WDATA <= {24'h0, d};
		BREADY <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge MCLK);
			if (aw_p && AWREADY) begin
				aw_p = 1'b0;
				AWVALID <= 1'b0;
			end
			if (w_p && WREADY) begin
				w_p = 1'b0;
				WVALID <= 1'b0;
			end
		end
		do @(posedge MCLK); while (BVALID !== 1'b1);
		wresp = BRESP;
		BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge MCLK);
		ARVALID <= 1'b1;
		ARADDR <= a;
		RREADY <= 1'b1;
		do @(posedge MCLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge MCLK); while (RVALID !== 1'b1);
		rdat = RDATA;
		rresp = RRESP;
		RREADY <= 1'b0;
	endtask
	task automatic trig();
		@(posedge MCLK);
		SPECIAL_EVENT <= 1'b1;
		@(posedge MCLK);
		SPECIAL_EVENT <= 1'b0;
	endtask
	// reset values, unmapped place, read-only bits of the second control
	task automatic t_regs();
		logic [7:0] adr [5] = '{`ADCC_CTRL0_ADDR, `ADCC_CTRL1_ADDR, `ADCC_RESULT_ADDR,
			`ADCC_STATUS_ADDR, `ADCC_MASK_ADDR};
		foreach (adr[i]) begin
			rd(adr[i]);
			chk(rdat, 32'h0);
		end
		rd(8'h14);
		chk(32'(rresp), 32'(`ADCC_RESP_SLVERR));
		wr(8'h14, 8'hff);
		chk(32'(wresp), 32'(`ADCC_RESP_SLVERR));
		wr(`ADCC_CTRL1_ADDR, 8'hff);
		rd(`ADCC_CTRL1_ADDR);
		chk(rdat, 32'(`ADCC_CTRL1_MASK));
		chk(32'(ADC_REF_SEL), 32'h3);
		wr(`ADCC_CTRL1_ADDR, 8'h0);
	endtask
	// every input code, with the unused top bits written as ones
	task automatic t_sel();
		for (int i = 0; i < 16; i++) begin
			wr(`ADCC_CTRL0_ADDR, {2'h3, i[3:0], 2'h1});
			rd(`ADCC_CTRL0_ADDR);
			chk(rdat, {26'h0, i[3:0], 2'h1});
			chk(32'(ADC_CHAN_EN), (i < 14) ? 32'h1 << i : 32'h0);
			chk(32'(ADC_FIXED_REFERENCE_EN), 32'(i == 15));
		end
		wr(`ADCC_CTRL0_ADDR, 8'h0);
		chk(32'(ADC_FIXED_REFERENCE_EN | ADC_POWER), 32'h0);
	endtask
	// software start, power first, unmasked flag raises the interrupt
	task automatic t_conv();
		COMP_IN <= 1'b1;
		wr(`ADCC_MASK_ADDR, 8'h1);
		wr(`ADCC_CTRL0_ADDR, 8'h01);
		wr(`ADCC_CTRL0_ADDR, 8'h03);
		rd(`ADCC_CTRL0_ADDR);
		chk(rdat, 32'h3);
		t0 = cyc;
		while (IRQ !== 1'b1 && cyc - t0 < 600)
			@(posedge MCLK);
		chk(32'(IRQ), 32'h1);
		rd(`ADCC_CTRL0_ADDR);
		chk(rdat, 32'h1);
		rd(`ADCC_RESULT_ADDR);
		chk(rdat, 32'hff);
		rd(`ADCC_STATUS_ADDR);
		chk(rdat, 32'h1);
		rd(`ADCC_STATUS_ADDR);
		chk(rdat, 32'h0);
		chk(32'(IRQ), 32'h0);
	endtask
	// hardware start, masked, second trigger during acquisition
	task automatic t_trig();
		COMP_IN <= 1'b0;
		wr(`ADCC_MASK_ADDR, 8'h0);
		t0 = cyc;
		trig();
		rd(`ADCC_CTRL0_ADDR);
		chk(rdat, 32'h3);
		repeat (200) @(posedge MCLK);
		trig();
		do rd(`ADCC_CTRL0_ADDR); while (rdat[1] && cyc - t0 < 700);
		chk(32'(cyc - t0 < 480), 32'h1);
		rd(`ADCC_RESULT_ADDR);
		chk(rdat, 32'h0);
		chk(32'(IRQ), 32'h0);
		rd(`ADCC_STATUS_ADDR);
		chk(rdat, 32'h1);
	endtask
	// abort once the first decision shows, landing after the second; unresolved bits follow the last
	task automatic t_abort();
		COMP_IN <= 1'b1;
		wr(`ADCC_CTRL0_ADDR, 8'h03);
		t0 = cyc;
		while (ADC_DAC !== 8'hc0 && cyc - t0 < 600)
			@(posedge MCLK);
		wr(`ADCC_CTRL0_ADDR, 8'h01);
		rd(`ADCC_CTRL0_ADDR);
		chk(rdat, 32'h1);
		rd(`ADCC_RESULT_ADDR);
		chk(rdat, 32'hff);
		// switching off while sampling stops with no bit decided
		wr(`ADCC_CTRL0_ADDR, 8'h03);
		wr(`ADCC_CTRL0_ADDR, 8'h00);
		rd(`ADCC_CTRL0_ADDR);
		chk(rdat, 32'h0);
		rd(`ADCC_RESULT_ADDR);
		chk(rdat, 32'h0);
	endtask
	initial begin
		repeat (12) @(posedge MCLK);
		RST_B <= 1'b1;
		t_regs();
		t_sel();
		t_conv();
		t_trig();
		t_abort();
		complete_run();
	end
endmodule
`default_nettype wire
